// *** src/pqfc_pkg.sv ***
// shared constants and types of the packet queue and flow control block
package pqfc_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [4:0] PQFC_A_AGG_CFG = 5'h00;
    localparam logic [4:0] PQFC_A_QPTR_RST = 5'h01;
    localparam logic [4:0] PQFC_A_CONN_EN = 5'h02;
    localparam logic [4:0] PQFC_A_TX_SIZE = 5'h03;
    localparam logic [4:0] PQFC_A_RX_SIZE = 5'h04;
    localparam logic [4:0] PQFC_A_TX_HI = 5'h05;
    localparam logic [4:0] PQFC_A_TX_LO = 5'h06;
    localparam logic [4:0] PQFC_A_RX_HI = 5'h07;
    localparam logic [4:0] PQFC_A_RX_LO = 5'h08;
    localparam logic [4:0] PQFC_A_TX_LAT = 5'h09;
    localparam logic [4:0] PQFC_A_TX_IE = 5'h0a;
    localparam logic [4:0] PQFC_A_RX_LAT = 5'h0b;
    localparam logic [4:0] PQFC_A_RX_IE = 5'h0c;
    localparam logic [4:0] PQFC_A_GL_IE = 5'h0d;
    localparam logic [4:0] PQFC_A_GL_IS = 5'h0e;
    localparam logic [4:0] PQFC_A_FC_CFG = 5'h0f;
    localparam logic [4:0] PQFC_A_PAUSE_LO = 5'h10;
    localparam logic [4:0] PQFC_A_PAUSE_HI = 5'h11;
    localparam logic [4:0] PQFC_A_RX_CNT_LO = 5'h12;
    localparam logic [4:0] PQFC_A_RX_CNT_HI = 5'h13;
    localparam logic [4:0] PQFC_A_TX_CNT_LO = 5'h14;
    localparam logic [4:0] PQFC_A_TX_CNT_HI = 5'h15;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int PQFC_B_RX_EN = 0;
    localparam int PQFC_B_SEND_EN = 1;
    localparam int PQFC_B_LINK0 = 2;
    localparam int PQFC_B_HI = 0;
    localparam int PQFC_B_LO = 1;
    localparam int PQFC_B_AUTO = 0;
    localparam int PQFC_B_FCE = 1;
    localparam int PQFC_B_FCB = 2;
    localparam int PQFC_B_JAM_ENABLE_BIT = 3;
    localparam int PQFC_B_FDX = 4;
    // ************************************************************
    // sizes, counts and reset values
    // ************************************************************
    localparam int PQFC_BLOCK_PKTS = 32;
    localparam int PQFC_BLOCK_SHIFT = 5;
    localparam int PQFC_PKT_BYTES = 2048;
    localparam int PQFC_SDRAM_SLOTS = 8192;
    localparam int PQFC_SLOT_W = 13;
    localparam int PQFC_LINKS = 4;
    localparam logic [2:0] PQFC_JAM_BYTES = 3'h4;
    localparam logic [4:0] PQFC_FC_RST = 5'h01;
    localparam logic [15:0] PQFC_PAUSE_RST = 16'h0050;
    localparam logic [7:0] PQFC_IDLE_BYTE = 8'hff;

    typedef enum logic [1:0] {
        PQFC_JAM_IDLE = 2'b01,
        PQFC_JAM_ACTIVE = 2'b10
    } pqfc_jam_t;

    // one transfer request toward the sdram arbiter
    typedef struct packed {
        logic valid;
        logic wr;
    } pqfc_req_t;

    typedef struct packed {
        logic [7:0] agg_cfg;
        logic conn_en;
        logic [7:0] tx_size;
        logic [7:0] rx_size;
        logic [7:0] tx_hi;
        logic [7:0] tx_lo;
        logic [7:0] rx_hi;
        logic [7:0] rx_lo;
        logic [1:0] tx_lat;
        logic [1:0] tx_ie;
        logic [1:0] rx_lat;
        logic [1:0] rx_ie;
        logic [1:0] gl_ie;
        logic [4:0] fc_cfg;
        logic [15:0] pause_val;
        logic [12:0] tx_wp;
        logic [12:0] tx_rp;
        logic [12:0] tx_cnt;
        logic [12:0] rx_wp;
        logic [12:0] rx_rp;
        logic [12:0] rx_cnt;
        logic tx_above_hi;
        logic tx_above_lo;
        logic rx_above_hi;
        logic rx_above_lo;
        logic [7:0] rdata;
        logic arb_last_hdlc;
        logic gnt_mac;
        logic gnt_hdlc;
        logic cmd_valid;
        logic cmd_wr;
        logic [12:0] cmd_slot;
        logic [1:0] link_sel;
        logic [7:0] stripe_byte;
        logic [1:0] stripe_link;
        logic stripe_valid;
        logic [7:0] hdlc_rx_byte;
        logic hdlc_rx_valid;
        logic hdlc_clk_en;
        logic pause_req;
        pqfc_jam_t jam_st;
        logic [2:0] jam_cnt;
        logic irq;
    } pqfc_state_t;
endpackage : pqfc_pkg

// *** src/pqfc_top.sv ***
// packet queue manager, sdram arbiter, link striping and ethernet flow control
// ************************************************************
// Summary of operation
// - outgoing bytes go one at a time to each enabled link in turn.
// - one connection with a receive queue and a transmit queue.
// - queue size counts blocks of 32 packet slots of 2048 bytes.
// - the connection may be unidirectional or bidirectional, per the agg_cfg send and receive enables.
// - disconnect flushes queues, sends ones outward, stops hdlc clock.
// - rising past high watermark latches a flag and may interrupt.
// - reading a latched threshold register clears its flags.
// - crossing the low watermark latches a separate flag.
// - receive queue has its own size, watermarks, flags and enables.
// - no overlap check and no error for overlapping queues.
// - arbiter grants mac and hdlc requests to the single sdram.
// - half duplex flow control jams to force remote collisions.
// - full duplex flow control sends pause with programmed timer.
// - auto mode owns pause bits, driven by receive high threshold.
// - auto full duplex pauses on each frame while above threshold.
// - auto half duplex jams 4 bytes of each new frame above threshold.
// ************************************************************
`timescale 1ns/1ps
`default_nettype none
module pqfc_top
    import pqfc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // register port
    input wire logic [4:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rd_data_out,
    // sdram arbiter
    input wire pqfc_req_t mac_req_in,
    input wire pqfc_req_t hdlc_req_in,
    input wire logic sdram_busy_in,
    output logic mac_gnt_out,
    output logic hdlc_gnt_out,
    output logic sdram_cmd_valid_out,
    output logic sdram_cmd_wr_out,
    output logic [12:0] sdram_slot_out,
    // serial side
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_byte_valid_in,
    input wire logic [7:0] link_rx_byte_in,
    input wire logic link_rx_valid_in,
    output logic [7:0] stripe_byte_out,
    output logic [1:0] stripe_link_out,
    output logic stripe_valid_out,
    output logic [7:0] hdlc_rx_byte_out,
    output logic hdlc_rx_valid_out,
    output logic hdlc_clk_en_out,
    // mac flow control
    input wire logic mac_frame_start_in,
    input wire logic mac_frame_end_in,
    input wire logic mac_rx_byte_in,
    output logic pause_req_out,
    output logic [15:0] pause_timer_out,
    output logic jam_out,
    output logic queue_irq_out
);
    pqfc_state_t s_r;
    pqfc_state_t s_nxt;

    logic [12:0] tx_lim;
    logic [12:0] rx_lim;
    logic tx_hi_now;
    logic tx_lo_now;
    logic rx_hi_now;
    logic rx_lo_now;
    logic [1:0] tx_set;
    logic [1:0] rx_set;
    logic auto_fc;
    logic fce_eff;
    logic mac_ok;
    logic hdlc_ok;
    logic pick_mac;
    logic pick_hdlc;
    logic tx_enq;
    logic tx_deq;
    logic rx_enq;
    logic rx_deq;
    logic qptr_rst;
    logic [3:0] link_en;

    function automatic logic [12:0] inc_wrap(input logic [12:0] ptr, input logic [12:0] lim);
        logic [12:0] p1;
        p1 = ptr + 13'h0001;
        return (p1 == lim) ? 13'h0000 : p1;
    endfunction : inc_wrap

    // next enabled link after the current one, wrapping round
    function automatic logic [1:0] next_link(input logic [1:0] sel, input logic [3:0] en);
        logic [1:0] c;
        logic [1:0] res;
        logic found;
        res = sel;
        found = 1'b0;
        for (int i = 1; i <= PQFC_LINKS; i++) begin
            c = sel + 2'(i);
            if (!found && en[c]) begin
                res = c;
                found = 1'b1;
            end
        end
        return res;
    endfunction : next_link

    // ************************************************************
    // queue occupancy and watermarks
    // ************************************************************
    assign tx_lim = {s_r.tx_size, 5'h00};
    assign rx_lim = {s_r.rx_size, 5'h00};
    assign tx_hi_now = s_r.tx_cnt > {s_r.tx_hi, 5'h00};
    assign tx_lo_now = s_r.tx_cnt > {s_r.tx_lo, 5'h00};
    assign rx_hi_now = s_r.rx_cnt > {s_r.rx_hi, 5'h00};
    assign rx_lo_now = s_r.rx_cnt > {s_r.rx_lo, 5'h00};
    assign tx_set = {tx_lo_now != s_r.tx_above_lo, tx_hi_now & ~s_r.tx_above_hi};
    assign rx_set = {rx_lo_now != s_r.rx_above_lo, rx_hi_now & ~s_r.rx_above_hi};
    assign auto_fc = s_r.fc_cfg[PQFC_B_AUTO];
    assign fce_eff = auto_fc | s_r.fc_cfg[PQFC_B_FCE];
    assign link_en = s_r.agg_cfg[PQFC_B_LINK0 +: PQFC_LINKS];
    assign qptr_rst = wr_in && addr_in == PQFC_A_QPTR_RST && wr_data_in[0];

    // ************************************************************
    // arbiter: mac enqueues rx / dequeues tx, hdlc the reverse
    // ************************************************************
    // a requester that sees its grant drops the request next cycle, so
    // it is not granted again while its grant is still showing
    assign mac_ok = mac_req_in.valid && s_r.conn_en && !s_r.gnt_mac
        && (mac_req_in.wr ? (s_r.rx_cnt != rx_lim) : (s_r.tx_cnt != 13'h0000));
    assign hdlc_ok = hdlc_req_in.valid && s_r.conn_en && !s_r.gnt_hdlc
        && (hdlc_req_in.wr ? (s_r.tx_cnt != tx_lim) : (s_r.rx_cnt != 13'h0000));
    assign pick_mac = !sdram_busy_in && mac_ok && (!hdlc_ok || s_r.arb_last_hdlc);
    assign pick_hdlc = !sdram_busy_in && hdlc_ok && !pick_mac;
    assign rx_enq = pick_mac && mac_req_in.wr;
    assign tx_deq = pick_mac && !mac_req_in.wr;
    assign tx_enq = pick_hdlc && hdlc_req_in.wr;
    assign rx_deq = pick_hdlc && !hdlc_req_in.wr;

    always_comb begin
        s_nxt = s_r;
        // ************************************************************
        // register writes
        // ************************************************************
        if (wr_in) begin
            case (addr_in)
                PQFC_A_AGG_CFG: s_nxt.agg_cfg = wr_data_in;
                PQFC_A_CONN_EN: s_nxt.conn_en = wr_data_in[0];
                PQFC_A_TX_SIZE: s_nxt.tx_size = wr_data_in;
                PQFC_A_RX_SIZE: s_nxt.rx_size = wr_data_in;
                PQFC_A_TX_HI: s_nxt.tx_hi = wr_data_in;
                PQFC_A_TX_LO: s_nxt.tx_lo = wr_data_in;
                PQFC_A_RX_HI: s_nxt.rx_hi = wr_data_in;
                PQFC_A_RX_LO: s_nxt.rx_lo = wr_data_in;
                PQFC_A_TX_IE: s_nxt.tx_ie = wr_data_in[1:0];
                PQFC_A_RX_IE: s_nxt.rx_ie = wr_data_in[1:0];
                PQFC_A_GL_IE: s_nxt.gl_ie = wr_data_in[1:0];
                PQFC_A_FC_CFG: begin
                    s_nxt.fc_cfg[PQFC_B_AUTO] = wr_data_in[PQFC_B_AUTO];
                    s_nxt.fc_cfg[PQFC_B_FDX] = wr_data_in[PQFC_B_FDX];
                    s_nxt.fc_cfg[PQFC_B_JAM_ENABLE_BIT] = wr_data_in[PQFC_B_JAM_ENABLE_BIT];
                    // pause bits belong to the hardware in auto mode
                    if (!auto_fc) begin
                        s_nxt.fc_cfg[PQFC_B_FCE] = wr_data_in[PQFC_B_FCE];
                        s_nxt.fc_cfg[PQFC_B_FCB] = wr_data_in[PQFC_B_FCB];
                    end
                end
                PQFC_A_PAUSE_LO: s_nxt.pause_val[7:0] = wr_data_in;
                PQFC_A_PAUSE_HI: s_nxt.pause_val[15:8] = wr_data_in;
                default: s_nxt.rdata = s_r.rdata;
            endcase
        end
        // ************************************************************
        // latched flags: a new crossing beats the read clear
        // ************************************************************
        s_nxt.tx_lat = ((rd_in && addr_in == PQFC_A_TX_LAT) ? 2'b00 : s_r.tx_lat) | tx_set;
        s_nxt.rx_lat = ((rd_in && addr_in == PQFC_A_RX_LAT) ? 2'b00 : s_r.rx_lat) | rx_set;
        s_nxt.tx_above_hi = tx_hi_now;
        s_nxt.tx_above_lo = tx_lo_now;
        s_nxt.rx_above_hi = rx_hi_now;
        s_nxt.rx_above_lo = rx_lo_now;
        s_nxt.irq = (s_r.gl_ie[0] && |(s_r.tx_lat & s_r.tx_ie))
            || (s_r.gl_ie[1] && |(s_r.rx_lat & s_r.rx_ie));
        // ************************************************************
        // register reads, answered in the following cycle
        // ************************************************************
        s_nxt.rdata = 8'h00;
        if (rd_in) begin
            case (addr_in)
                PQFC_A_AGG_CFG: s_nxt.rdata = s_r.agg_cfg;
                PQFC_A_CONN_EN: s_nxt.rdata = {7'h00, s_r.conn_en};
                PQFC_A_TX_SIZE: s_nxt.rdata = s_r.tx_size;
                PQFC_A_RX_SIZE: s_nxt.rdata = s_r.rx_size;
                PQFC_A_TX_HI: s_nxt.rdata = s_r.tx_hi;
                PQFC_A_TX_LO: s_nxt.rdata = s_r.tx_lo;
                PQFC_A_RX_HI: s_nxt.rdata = s_r.rx_hi;
                PQFC_A_RX_LO: s_nxt.rdata = s_r.rx_lo;
                PQFC_A_TX_LAT: s_nxt.rdata = {6'h00, s_r.tx_lat};
                PQFC_A_TX_IE: s_nxt.rdata = {6'h00, s_r.tx_ie};
                PQFC_A_RX_LAT: s_nxt.rdata = {6'h00, s_r.rx_lat};
                PQFC_A_RX_IE: s_nxt.rdata = {6'h00, s_r.rx_ie};
                PQFC_A_GL_IE: s_nxt.rdata = {6'h00, s_r.gl_ie};
                PQFC_A_GL_IS: s_nxt.rdata = {6'h00, |(s_r.rx_lat & s_r.rx_ie),
                    |(s_r.tx_lat & s_r.tx_ie)};
                PQFC_A_FC_CFG: s_nxt.rdata = {3'h0, s_r.fc_cfg[4:3],
                    auto_fc ? s_r.pause_req : s_r.fc_cfg[PQFC_B_FCB], fce_eff,
                    auto_fc};
                PQFC_A_PAUSE_LO: s_nxt.rdata = s_r.pause_val[7:0];
                PQFC_A_PAUSE_HI: s_nxt.rdata = s_r.pause_val[15:8];
                PQFC_A_RX_CNT_LO: s_nxt.rdata = s_r.rx_cnt[7:0];
                PQFC_A_RX_CNT_HI: s_nxt.rdata = {3'h0, s_r.rx_cnt[12:8]};
                PQFC_A_TX_CNT_LO: s_nxt.rdata = s_r.tx_cnt[7:0];
                PQFC_A_TX_CNT_HI: s_nxt.rdata = {3'h0, s_r.tx_cnt[12:8]};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        // ************************************************************
        // queue pointers and sdram command
        // ************************************************************
        s_nxt.gnt_mac = pick_mac;
        s_nxt.gnt_hdlc = pick_hdlc;
        s_nxt.cmd_valid = pick_mac || pick_hdlc;
        s_nxt.cmd_wr = rx_enq || tx_enq;
        if (pick_mac || pick_hdlc) begin
            s_nxt.arb_last_hdlc = pick_hdlc;
        end
        // rx region sits right after tx; overlap is the host's concern
        if (tx_enq) begin
            s_nxt.cmd_slot = s_r.tx_wp;
        end else if (tx_deq) begin
            s_nxt.cmd_slot = s_r.tx_rp;
        end else if (rx_enq) begin
            s_nxt.cmd_slot = 13'(tx_lim + s_r.rx_wp);
        end else if (rx_deq) begin
            s_nxt.cmd_slot = 13'(tx_lim + s_r.rx_rp);
        end
        if (tx_enq) begin
            s_nxt.tx_wp = inc_wrap(s_r.tx_wp, tx_lim);
            s_nxt.tx_cnt = s_r.tx_cnt + 13'h0001;
        end
        if (tx_deq) begin
            s_nxt.tx_rp = inc_wrap(s_r.tx_rp, tx_lim);
            s_nxt.tx_cnt = s_r.tx_cnt - 13'h0001;
        end
        if (rx_enq) begin
            s_nxt.rx_wp = inc_wrap(s_r.rx_wp, rx_lim);
            s_nxt.rx_cnt = s_r.rx_cnt + 13'h0001;
        end
        if (rx_deq) begin
            s_nxt.rx_rp = inc_wrap(s_r.rx_rp, rx_lim);
            s_nxt.rx_cnt = s_r.rx_cnt - 13'h0001;
        end
        if (qptr_rst || !s_r.conn_en) begin
            s_nxt.tx_wp = 13'h0000;
            s_nxt.tx_rp = 13'h0000;
            s_nxt.tx_cnt = 13'h0000;
            s_nxt.rx_wp = 13'h0000;
            s_nxt.rx_rp = 13'h0000;
            s_nxt.rx_cnt = 13'h0000;
        end
        // ************************************************************
        // serial side: striping and idle ones while disconnected
        // ************************************************************
        s_nxt.stripe_valid = tx_byte_valid_in;
        s_nxt.stripe_link = s_r.link_sel;
        s_nxt.stripe_byte = PQFC_IDLE_BYTE;
        if (s_r.conn_en && s_r.agg_cfg[PQFC_B_SEND_EN] && link_en != 4'h0) begin
            if (!link_en[s_r.link_sel]) begin
                s_nxt.link_sel = next_link(s_r.link_sel, link_en);
            end else if (tx_byte_valid_in) begin
                s_nxt.stripe_byte = tx_byte_in;
                s_nxt.link_sel = next_link(s_r.link_sel, link_en);
            end
        end
        s_nxt.hdlc_rx_valid = link_rx_valid_in;
        s_nxt.hdlc_rx_byte = (s_r.conn_en && s_r.agg_cfg[PQFC_B_RX_EN])
            ? link_rx_byte_in : PQFC_IDLE_BYTE;
        s_nxt.hdlc_clk_en = s_r.conn_en;
        // ************************************************************
        // flow control: pause in full duplex, jam in half duplex
        // ************************************************************
        s_nxt.pause_req = 1'b0;
        if (s_r.fc_cfg[PQFC_B_FDX] && fce_eff) begin
            if (auto_fc) begin
                s_nxt.pause_req = rx_hi_now && mac_frame_end_in;
            end else if (s_r.fc_cfg[PQFC_B_FCB]) begin
                s_nxt.pause_req = 1'b1;
                s_nxt.fc_cfg[PQFC_B_FCB] = 1'b0;
            end
        end
        case (s_r.jam_st)
            PQFC_JAM_IDLE: begin
                s_nxt.jam_cnt = 3'h0;
                // only a frame that starts now is jammed, never the one in flight
                if (!s_r.fc_cfg[PQFC_B_FDX] && fce_eff && mac_frame_start_in
                    && (auto_fc ? rx_hi_now : s_r.fc_cfg[PQFC_B_JAM_ENABLE_BIT])) begin
                    s_nxt.jam_st = PQFC_JAM_ACTIVE;
                end
            end
            PQFC_JAM_ACTIVE: begin
                if (mac_rx_byte_in) begin
                    s_nxt.jam_cnt = s_r.jam_cnt + 3'h1;
                    if (s_r.jam_cnt == PQFC_JAM_BYTES - 3'h1) begin
                        s_nxt.jam_st = PQFC_JAM_IDLE;
                    end
                end
            end
            default: s_nxt.jam_st = PQFC_JAM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '0;
            s_r.fc_cfg <= PQFC_FC_RST;
            s_r.pause_val <= PQFC_PAUSE_RST;
            s_r.jam_st <= PQFC_JAM_IDLE;
            s_r.stripe_byte <= PQFC_IDLE_BYTE;
            s_r.hdlc_rx_byte <= PQFC_IDLE_BYTE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data_out = s_r.rdata;
    assign mac_gnt_out = s_r.gnt_mac;
    assign hdlc_gnt_out = s_r.gnt_hdlc;
    assign sdram_cmd_valid_out = s_r.cmd_valid;
    assign sdram_cmd_wr_out = s_r.cmd_wr;
    assign sdram_slot_out = s_r.cmd_slot;
    assign stripe_byte_out = s_r.stripe_byte;
    assign stripe_link_out = s_r.stripe_link;
    assign stripe_valid_out = s_r.stripe_valid;
    assign hdlc_rx_byte_out = s_r.hdlc_rx_byte;
    assign hdlc_rx_valid_out = s_r.hdlc_rx_valid;
    assign hdlc_clk_en_out = s_r.hdlc_clk_en;
    assign pause_req_out = s_r.pause_req;
    assign pause_timer_out = s_r.pause_val;
    assign jam_out = s_r.jam_st == PQFC_JAM_ACTIVE;
    assign queue_irq_out = s_r.irq;

    // ************************************************************
    // checks
    // ************************************************************
    read_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (rd_in && addr_in == PQFC_A_TX_LAT && tx_set == 2'b00) |=> (s_r.tx_lat == 2'b00))
        else $error("tx latched flags not cleared by read");
    disc_ones_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !s_r.conn_en |=> (stripe_byte_out == 8'hff && hdlc_rx_byte_out == 8'hff
            && !hdlc_clk_en_out))
        else $error("disconnected outputs not idle");
    flush_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !s_r.conn_en |=> (s_r.tx_cnt == 13'h0000 && s_r.rx_cnt == 13'h0000))
        else $error("queues not flushed on disconnect");
    high_flag_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (tx_hi_now && !s_r.tx_above_hi) |=> s_r.tx_lat[PQFC_B_HI])
        else $error("tx high crossing not latched");
    low_flag_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (rx_lo_now != s_r.rx_above_lo) |=> s_r.rx_lat[PQFC_B_LO])
        else $error("rx low crossing not latched");
    jam_len_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (jam_out && mac_rx_byte_in && s_r.jam_cnt == 3'h3) |=> !jam_out)
        else $error("jam longer than four bytes");
    pause_auto_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (auto_fc && s_r.fc_cfg[PQFC_B_FDX] && rx_hi_now && mac_frame_end_in)
            |=> pause_req_out)
        else $error("no pause for frame above high threshold");
    grant_excl_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (mac_gnt_out || hdlc_gnt_out) |-> (!(mac_gnt_out && hdlc_gnt_out)
            && sdram_cmd_valid_out))
        else $error("bad sdram grant");
endmodule : pqfc_top
`default_nettype wire

// *** testbench/pqfc_req_model.sv ***
// requester model that holds a transfer request until it is granted
`timescale 1ns/1ps
`default_nettype none
module pqfc_req_model
    import pqfc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // control
    input wire logic go_in,
    input wire logic wr_in,
    input wire logic gnt_in,
    output pqfc_req_t req_out
);
    // request drops only after its grant is seen, never early
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) req_out <= '0;
        else if (go_in) req_out <= '{valid: 1'b1, wr: wr_in};
        else if (gnt_in) req_out <= '0;
    end
endmodule : pqfc_req_model
`default_nettype wire

// *** testbench/pqfc_top_tb.sv ***
// self-checking bench for the packet queue and flow control block
`timescale 1ns/1ps
`default_nettype none
module pqfc_top_tb;
    import pqfc_pkg::*;
    logic clk_sys_in = 0, rst_in = 1, wr = 0, rd = 0, go = 0, tv = 0, fe = 0, z = 0;
    logic go2 = 0, qw = 0, fs = 0, rb = 0;
    logic [4:0] addr = '0;
    logic [7:0] wd = '0, rdat, sb, hb, tb = '0;
    logic [1:0] sl;
    logic mg, hg, sv, hv, cv, cw, hce, pr, jm, qi;
    logic [12:0] slot;
    logic [15:0] pt;
    pqfc_req_t mreq, hreq;
    int fails = 0, check_count = 0, cyc = 0;
    always #2.5 clk_sys_in = ~clk_sys_in;
    pqfc_req_model mdl (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .go_in(go), .wr_in(qw),
        .gnt_in(mg), .req_out(mreq));
    pqfc_req_model hmdl (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .go_in(go2), .wr_in(qw),
        .gnt_in(hg), .req_out(hreq));
    pqfc_top dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wd),
        .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .mac_req_in(mreq), .hdlc_req_in(hreq),
        .sdram_busy_in(z), .mac_gnt_out(mg), .hdlc_gnt_out(hg), .sdram_cmd_valid_out(cv),
        .sdram_cmd_wr_out(cw), .sdram_slot_out(slot), .tx_byte_in(tb), .tx_byte_valid_in(tv),
        .link_rx_byte_in(tb), .link_rx_valid_in(tv), .stripe_byte_out(sb),
        .stripe_link_out(sl), .stripe_valid_out(sv), .hdlc_rx_byte_out(hb),
        .hdlc_rx_valid_out(hv), .hdlc_clk_en_out(hce), .mac_frame_start_in(fs),
        .mac_frame_end_in(fe), .mac_rx_byte_in(rb), .pause_req_out(pr),
        .pause_timer_out(pt), .jam_out(jm), .queue_irq_out(qi));
    task automatic ck(input string n, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : ck
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys_in) begin wr <= 1; addr <= a; wd <= d; end
        @(posedge clk_sys_in) wr <= 0;
    endtask : wreg
    task automatic rreg(input logic [4:0] a, input logic [7:0] e, input string n);
        @(posedge clk_sys_in) begin rd <= 1; addr <= a; end
        @(posedge clk_sys_in) rd <= 0;
        #1 ck(n, {8'h00, e}, {8'h00, rdat});
    endtask : rreg
    task automatic enq(input logic h, input logic w, input logic [12:0] e);
        int k;
        @(posedge clk_sys_in) begin go <= !h; go2 <= h; qw <= w; end
        @(posedge clk_sys_in) begin go <= 0; go2 <= 0; end
        for (k = 0; k < 10 && (h ? hg : mg) !== 1'b1; k++) begin
            @(posedge clk_sys_in);
            #1;
        end
        ck("slot", {3'h0, e}, {3'h0, slot});
        ck("cmd", {14'h0, 1'b1, w}, {14'h0, cv, cw});
    endtask : enq
    task automatic t_stripe();
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys_in) begin tv <= 1; tb <= 8'ha5 + i[7:0]; end
            @(posedge clk_sys_in) tv <= 0;
            #1 ck("stripe", {5'h0, 1'b1, 2'(i), 8'ha5 + i[7:0]}, {5'h0, sv, sl, sb});
            ck("hdlc rx", {7'h0, 1'b1, 8'ha5 + i[7:0]}, {7'h0, hv, hb});
        end
    endtask : t_stripe
    task automatic t_fill();
        for (int i = 0; i < 33; i++) enq(1'b0, 1'b1, 13'd32 + 13'(i));
        rreg(PQFC_A_RX_CNT_LO, 8'd33, "rx count");
        ck("irq", 16'h0001, {15'h0, qi});
        rreg(PQFC_A_RX_LAT, 8'h03, "rx latched");
        rreg(PQFC_A_RX_LAT, 8'h00, "rx latched clear");
        ck("irq clear", 16'h0000, {15'h0, qi});
        @(posedge clk_sys_in) fe <= 1;
        @(posedge clk_sys_in) fe <= 0;
        #1 ck("pause", 16'h0001, {15'h0, pr});
    endtask : t_fill
    task automatic t_jam();
        wreg(PQFC_A_FC_CFG, 8'h01);
        @(posedge clk_sys_in) fs <= 1;
        @(posedge clk_sys_in) begin fs <= 0; rb <= 1; end
        #1 ck("jam on", 16'h0001, {15'h0, jm});
        repeat (3) @(posedge clk_sys_in);
        #1 ck("jam held", 16'h0001, {15'h0, jm});
        @(posedge clk_sys_in) rb <= 0;
        #1 ck("jam off", 16'h0000, {15'h0, jm});
    endtask : t_jam
    task automatic t_manual();
        wreg(PQFC_A_FC_CFG, 8'h10);
        wreg(PQFC_A_PAUSE_LO, 8'h34);
        wreg(PQFC_A_FC_CFG, 8'h16);
        @(posedge clk_sys_in) #1 ck("manual pause", 16'h0001, {15'h0, pr});
        ck("timer set", 16'h0034, pt);
        rreg(PQFC_A_FC_CFG, 8'h12, "fcb clear");
    endtask : t_manual
    task automatic t_hdlc();
        enq(1'b1, 1'b0, 13'd32);
        enq(1'b1, 1'b1, 13'd0);
        rreg(PQFC_A_TX_LAT, 8'h03, "tx latched");
        enq(1'b0, 1'b0, 13'd0);
        rreg(PQFC_A_TX_LAT, 8'h02, "tx low cross");
    endtask : t_hdlc
    task automatic end_sim();
        $display("fails %0d check_count %0d", fails, check_count);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // a hang is cut short well above the expected run length
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 0;
        #1 ck("reset", {PQFC_IDLE_BYTE, PQFC_IDLE_BYTE}, {sb, hb});
        ck("reset clk", 16'h0000, {15'h0, hce});
        ck("timer", PQFC_PAUSE_RST, pt);
        wreg(PQFC_A_TX_SIZE, 8'h01);
        wreg(PQFC_A_RX_SIZE, 8'h02);
        wreg(PQFC_A_RX_HI, 8'h01);
        wreg(PQFC_A_RX_IE, 8'h01);
        wreg(PQFC_A_GL_IE, 8'h02);
        wreg(PQFC_A_FC_CFG, 8'h11);
        wreg(PQFC_A_AGG_CFG, 8'h0f);
        wreg(PQFC_A_QPTR_RST, 8'h01);
        wreg(PQFC_A_CONN_EN, 8'h01);
        rreg(PQFC_A_FC_CFG, 8'h13, "fc cfg");
        #5 ck("hdlc clk", 16'h0001, {15'h0, hce});
        t_stripe();
        t_fill();
        t_jam();
        t_manual();
        t_hdlc();
        wreg(PQFC_A_CONN_EN, 8'h00);
        rreg(PQFC_A_RX_CNT_LO, 8'h00, "flush");
        ck("idle", {PQFC_IDLE_BYTE, PQFC_IDLE_BYTE}, {sb, hb});
        ck("clk off", 16'h0000, {15'h0, hce});
        wreg(PQFC_A_TX_SIZE, 8'h02);
        wreg(PQFC_A_QPTR_RST, 8'h01);
        wreg(PQFC_A_CONN_EN, 8'h01);
        enq(1'b0, 1'b1, 13'd64);
        end_sim();
    end
endmodule : pqfc_top_tb
`default_nettype wire
